// File: hdl/data_memory_decode_dual_pointer.sv
`timescale 1ns/10ps
module data_memory_decode_dual_pointer #(
   parameter int SCR_DEPTH = 256,
   parameter int XRAM_DEPTH = 1024
) (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_clk_en,
   input wire logic [7:0] i_dir_addr,
   input wire logic i_dir_wr,
   input wire logic [7:0] i_dir_wdata,
   output logic [7:0] o_dir_rdata,
   input wire logic [7:0] i_ind_addr,
   input wire logic i_ind_wr,
   input wire logic [7:0] i_ind_wdata,
   output logic [7:0] o_ind_rdata,
   input wire logic [7:0] i_bit_addr,
   input wire logic i_bit_wr,
   input wire logic i_bit_val,
   output logic o_bit_rdata,
   input wire logic i_sp_push,
   input wire logic i_sp_pop,
   output logic [7:0] o_stack_top,
   input wire logic i_dp_load,
   input wire logic [15:0] i_dp_wdata,
   input wire logic i_dp_inc,
   input wire logic i_dp_dec,
   output logic [15:0] o_active_data_pointer,
   input wire logic i_xm_req,
   input wire logic i_xm_wr,
   input wire logic [15:0] i_xm_addr,
   input wire logic [7:0] i_xm_wdata,
   input wire logic [2:0] i_stretch,
   output logic o_xm_busy,
   output logic o_xm_done,
   output logic [7:0] o_xm_rdata,
   input wire logic [7:0] i_low_address_port_in,
   output logic [7:0] o_low_address_port_out,
   output logic [7:0] o_low_address_port_oe_n,
   output logic [7:0] o_high_address_port,
   output logic o_ale,
   output logic o_rd_n,
   output logic o_wr_n
);
   import dmd_pkg::*;

   logic [7:0] scr_mem [0:SCR_DEPTH-1];
   logic [7:0] xram_mem [0:XRAM_DEPTH-1];
   logic [7:0] latch_reg;
   logic [7:0] sp_reg;
   logic [15:0] pa_reg;
   logic [15:0] pb_reg;
   logic psel_reg;
   logic dme_reg;
   xstate_t state_reg;
   logic [5:0] cnt_reg;
   logic [15:0] xaddr_reg;
   logic xwr_reg;
   logic [7:0] xwdata_reg;

   // Register read map; unimplemented locations and reserved PMR bits read as ones, reserved PSEL bits as zeros
   // unimplemented reads high
   function automatic logic [7:0] sfr_read(input logic [7:0] a);
      logic [7:0] v;
      v = UNIMPL_BYTE;
      case (a)
         ADDR_LOW_PORT: v = i_low_address_port_in;
         ADDR_STACK: v = sp_reg;
         ADDR_PA_LO: v = pa_reg[7:0];
         ADDR_PA_HI: v = pa_reg[15:8];
         ADDR_PB_LO: v = pb_reg[7:0];
         ADDR_PB_HI: v = pb_reg[15:8];
         ADDR_PSEL: v = {7'h00, psel_reg};
         ADDR_PMR: v = {7'h7F, dme_reg};
         default: v = UNIMPL_BYTE;
      endcase
      return v;
   endfunction : sfr_read

   // Merge direct and bit writes into one byte write; direct wins
   // bit target ends in 0 or 8 for bit addresses 80h and up; lower ones land in bytes 20h-2Fh
   wire [7:0] bit_byte = i_bit_addr[7] ? {i_bit_addr[7:3], 3'h0} : {4'h2, i_bit_addr[6:3]};
   logic [7:0] bit_cur;
   logic [7:0] rmw_cur;
   // Function reads module state, so a process that tracks it makes the call
   always_comb begin
      bit_cur = i_bit_addr[7] ? sfr_read(bit_byte) : scr_mem[bit_byte];
      // port bits modify the latch; pin levels would flip the others
      rmw_cur = (bit_byte == ADDR_LOW_PORT) ? latch_reg : bit_cur;
   end
   wire [7:0] bit_mask = 8'h01 << i_bit_addr[2:0];
   wire [7:0] bit_new = i_bit_val ? (rmw_cur | bit_mask) : (rmw_cur & ~bit_mask);
   wire use_bit = i_bit_wr & ~i_dir_wr;
   wire any_wr = i_dir_wr | i_bit_wr;
   wire [7:0] wa = use_bit ? bit_byte : i_dir_addr;
   wire [7:0] wd = use_bit ? bit_new : i_dir_wdata;
   wire sfr_we = any_wr & wa[7];
   wire scr_we = any_wr & ~wa[7];

   // Pointer pair update: register write first, then the pointer op if active
   function automatic logic [15:0] pair_next(input logic [15:0] cur,
                                            input logic [7:0] lo_a,
                                            input logic act);
      logic [15:0] v;
      v = cur;
      if (sfr_we && wa == lo_a) begin
         v[7:0] = wd;
      end
      if (sfr_we && wa == lo_a + 8'h01) begin
         v[15:8] = wd;
      end
      if (act && i_dp_load) begin
         v = i_dp_wdata;
      end else if (act && i_dp_inc) begin
         v = v + 16'h0001;
      end else if (act && i_dp_dec) begin
         v = v - 16'h0001;
      end
      return v;
   endfunction : pair_next

   wire psel_next = (sfr_we && wa == ADDR_PSEL) ? wd[PSEL_BIT] : psel_reg;
   logic [15:0] pa_next;
   logic [15:0] pb_next;
   // Pair updates in a process, so strobes read inside the function are tracked
   always_comb begin
      pa_next = pair_next(pa_reg, ADDR_PA_LO, ~psel_reg);
      pb_next = pair_next(pb_reg, ADDR_PB_LO, psel_reg);
   end
   wire dme_next = (sfr_we && wa == ADDR_PMR) ? wd[PMR_DME_BIT] : dme_reg;
   wire [7:0] latch_next = (sfr_we && wa == ADDR_LOW_PORT) ? wd : latch_reg;
   // stack top moves with push and pop
   wire [7:0] sp_step = i_sp_push ? sp_reg + 8'h01 : (i_sp_pop ? sp_reg - 8'h01 : sp_reg);
   wire [7:0] sp_next = (sfr_we && wa == ADDR_STACK) ? wd : sp_step;

   // Decode of an external-data move at acceptance
   // on-chip window when enabled
   wire onchip_hit = dme_reg && (i_xm_addr <= ONCHIP_LAST);
   wire accept = (state_reg == X_IDLE) && i_xm_req;
   wire [9:0] xram_idx = xaddr_reg[9:0];
   wire [5:0] strobe_cnt = 6'((i_stretch + 6'h01) * MC_CNT - 6'h01);

   // Control registers; reset leaves the first pointer pair active
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         latch_reg <= RST_LATCH;
         sp_reg <= RST_STACK;
         pa_reg <= RST_PTR;
         pb_reg <= RST_PTR;
         psel_reg <= RST_PSEL;
         dme_reg <= RST_DME;
      end else if (i_clk_en) begin
         latch_reg <= latch_next;
         sp_reg <= sp_next;
         pa_reg <= pa_next;
         pb_reg <= pb_next;
         psel_reg <= psel_next;
         dme_reg <= dme_next;
      end
   end

   // Registered views of the pointer and stack state
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_active_data_pointer <= RST_PTR;
         o_stack_top <= RST_STACK;
      end else if (i_clk_en) begin
         o_active_data_pointer <= psel_next ? pb_next : pa_next;
         o_stack_top <= sp_next;
      end
   end

   // Scratchpad: no reset on the array, it is plain storage
   // direct and indirect scratchpad paths
   always_ff @(posedge i_clk) begin
      if (i_clk_en) begin
         if (scr_we) begin
            scr_mem[wa] <= wd;
         end else if (i_ind_wr) begin
            scr_mem[i_ind_addr] <= i_ind_wdata;
         end
      end
   end

   // Read ports, one cycle latency, old data on a same-cycle write
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_dir_rdata <= 8'h00;
         o_ind_rdata <= 8'h00;
         o_bit_rdata <= 1'b0;
      end else if (i_clk_en) begin
         o_dir_rdata <= i_dir_addr[7] ? sfr_read(i_dir_addr) : scr_mem[i_dir_addr];
         o_ind_rdata <= scr_mem[i_ind_addr];
         o_bit_rdata <= bit_cur[i_bit_addr[2:0]];
      end
   end

   // On-chip data RAM, written and read in the last clock of the move
   always_ff @(posedge i_clk) begin
      if (i_clk_en && state_reg == X_ONCHIP && cnt_reg == 6'h00 && xwr_reg) begin
         xram_mem[xram_idx] <= xwdata_reg;
      end
   end

   // External-data move sequencer; one move at a time, requests while busy ignored
   // full 16-bit address kept
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state_reg <= X_IDLE;
         cnt_reg <= 6'h00;
         xaddr_reg <= 16'h0000;
         xwr_reg <= 1'b0;
         xwdata_reg <= 8'h00;
         o_xm_busy <= 1'b0;
         o_xm_done <= 1'b0;
         o_xm_rdata <= 8'h00;
         o_low_address_port_out <= 8'h00;
         o_low_address_port_oe_n <= 8'hFF;
         o_high_address_port <= 8'hFF;
         o_ale <= 1'b0;
         o_rd_n <= 1'b1;
         o_wr_n <= 1'b1;
      end else if (i_clk_en) begin
         o_xm_done <= 1'b0;
         case (state_reg)
            X_IDLE: begin
               // open drain: a zero latch bit pulls low
               o_low_address_port_out <= 8'h00;
               o_low_address_port_oe_n <= latch_reg;
               if (accept) begin
                  xaddr_reg <= i_xm_addr;
                  xwr_reg <= i_xm_wr;
                  xwdata_reg <= i_xm_wdata;
                  o_xm_busy <= 1'b1;
                  if (onchip_hit) begin
                     state_reg <= X_ONCHIP;
                     cnt_reg <= ONCHIP_CNT;
                  end else begin
                     state_reg <= X_ADDR;
                     cnt_reg <= ADDR_CNT;
                     o_high_address_port <= i_xm_addr[15:8];
                     o_low_address_port_out <= i_xm_addr[7:0];
                     o_low_address_port_oe_n <= 8'h00;
                     o_ale <= 1'b1;
                  end
               end
            end
            X_ONCHIP: begin
               cnt_reg <= cnt_reg - 6'h01;
               if (cnt_reg == 6'h00) begin
                  if (!xwr_reg) begin
                     o_xm_rdata <= xram_mem[xram_idx];
                  end
                  o_xm_busy <= 1'b0;
                  o_xm_done <= 1'b1;
                  state_reg <= X_IDLE;
               end
            end
            X_ADDR: begin
               cnt_reg <= cnt_reg - 6'h01;
               if (cnt_reg == ALE_DROP) begin
                  o_ale <= 1'b0;
               end
               if (cnt_reg == 6'h00) begin
                  // Stretch lengthens only the strobe
                  state_reg <= X_STROBE;
                  cnt_reg <= strobe_cnt;
                  o_rd_n <= xwr_reg;
                  o_wr_n <= ~xwr_reg;
                  o_low_address_port_out <= xwr_reg ? xwdata_reg : 8'h00;
                  o_low_address_port_oe_n <= xwr_reg ? 8'h00 : 8'hFF;
               end
            end
            X_STROBE: begin
               cnt_reg <= cnt_reg - 6'h01;
               if (cnt_reg == 6'h00) begin
                  if (!xwr_reg) begin
                     o_xm_rdata <= i_low_address_port_in;
                  end
                  o_rd_n <= 1'b1;
                  o_wr_n <= 1'b1;
                  o_low_address_port_out <= 8'h00;
                  o_low_address_port_oe_n <= latch_reg;
                  o_high_address_port <= 8'hFF;
                  o_xm_busy <= 1'b0;
                  o_xm_done <= 1'b1;
                  state_reg <= X_IDLE;
               end
            end
            default: begin
               state_reg <= X_IDLE;
            end
         endcase
      end
   end

   // Checks below assume i_clk_en held high
   sequence s_addr_phase;
      o_ale [*2] ##1 !o_ale [*2];
   endsequence
   sequence s_read_strobe;
      !o_rd_n [*4] ##1 o_xm_done;
   endsequence

   property p_onchip_time;
      @(posedge i_clk) disable iff (!i_reset_n)
      accept && onchip_hit |=> !o_xm_done [*8] ##1 o_xm_done;
   endproperty
   a_onchip_time: assert property (p_onchip_time) else $error("on-chip move not 2 cycles");

   property p_onchip_quiet;
      @(posedge i_clk) disable iff (!i_reset_n)
      accept && onchip_hit |=> (o_rd_n && o_wr_n && !o_ale) [*8];
   endproperty
   a_onchip_quiet: assert property (p_onchip_quiet) else $error("bus moved on on-chip move");

   property p_ext_route;
      @(posedge i_clk) disable iff (!i_reset_n)
      accept && !onchip_hit |=> o_ale && o_low_address_port_oe_n == 8'h00 &&
         {o_high_address_port, o_low_address_port_out} == $past(i_xm_addr);
   endproperty
   a_ext_route: assert property (p_ext_route) else $error("address not on ports");

   property p_default_ext;
      @(posedge i_clk) disable iff (!i_reset_n)
      accept && !dme_reg |=> o_ale && o_xm_busy;
   endproperty
   a_default_ext: assert property (p_default_ext) else $error("move not external");

   property p_ext_read;
      @(posedge i_clk) disable iff (!i_reset_n)
      accept && !onchip_hit && !i_xm_wr && i_stretch == 3'h0 |=>
         s_addr_phase ##1 s_read_strobe;
   endproperty
   a_ext_read: assert property (p_ext_read) else $error("read cycle shape wrong");

   property p_psel_zero;
      @(posedge i_clk) disable iff (!i_reset_n)
      i_dir_addr == ADDR_PSEL |=> o_dir_rdata[7:1] == 7'h00;
   endproperty
   a_psel_zero: assert property (p_psel_zero) else $error("reserved select bits set");

   property p_unimpl_high;
      @(posedge i_clk) disable iff (!i_reset_n)
      i_dir_addr == 8'h87 |=> o_dir_rdata == 8'hFF;
   endproperty
   a_unimpl_high: assert property (p_unimpl_high) else $error("unimplemented not ones");

   property p_active_data_pointer_sel;
      @(posedge i_clk) disable iff (!i_reset_n)
      psel_reg && i_dp_inc && !i_dp_load && !sfr_we |=>
         o_active_data_pointer == $past(pb_reg) + 16'h0001 && pa_reg == $past(pa_reg);
   endproperty
   a_active_data_pointer_sel: assert property (p_active_data_pointer_sel) else $error("wrong pointer pair used");

   property p_stack_push;
      @(posedge i_clk) disable iff (!i_reset_n)
      i_clk_en && i_sp_push && !sfr_we |=> o_stack_top == $past(sp_reg) + 8'h01;
   endproperty
   a_stack_push: assert property (p_stack_push) else $error("stack top not advanced");

   property p_bit_align;
      @(posedge i_clk) disable iff (!i_reset_n)
      use_bit && !i_dp_load && !i_dp_inc && !i_dp_dec |=> pb_reg[15:8] == $past(pb_reg[15:8]);
   endproperty
   a_bit_align: assert property (p_bit_align) else $error("bit write hit odd register");

   property p_scratch_ind;
      @(posedge i_clk) disable iff (!i_reset_n)
      i_ind_wr && !any_wr ##1 i_ind_addr == $past(i_ind_addr) |=> o_ind_rdata == $past(i_ind_wdata, 2);
   endproperty
   a_scratch_ind: assert property (p_scratch_ind) else $error("scratchpad lost data");
endmodule : data_memory_decode_dual_pointer

// File: hdl/dmd_pkg.sv
package dmd_pkg;
   // Special-register locations served by this block
   localparam logic [7:0] ADDR_LOW_PORT = 8'h80;
   localparam logic [7:0] ADDR_STACK = 8'h81;
   localparam logic [7:0] ADDR_PA_LO = 8'h82;
   localparam logic [7:0] ADDR_PA_HI = 8'h83;
   localparam logic [7:0] ADDR_PB_LO = 8'h84;
   localparam logic [7:0] ADDR_PB_HI = 8'h85;
   localparam logic [7:0] ADDR_PSEL = 8'h86;
   localparam logic [7:0] ADDR_PMR = 8'hC4;
   // Field positions
   localparam int PSEL_BIT = 0;
   localparam int PMR_DME_BIT = 0;
   // Values after reset, and the byte that unimplemented locations read
   localparam logic [7:0] RST_STACK = 8'h07;
   localparam logic [7:0] RST_LATCH = 8'hFF;
   localparam logic [15:0] RST_PTR = 16'h0000;
   localparam logic RST_PSEL = 1'b0;
   localparam logic RST_DME = 1'b0;
   localparam logic [7:0] UNIMPL_BYTE = 8'hFF;
   // On-chip data RAM window
   localparam logic [15:0] ONCHIP_LAST = 16'h03FF;
   // Machine-cycle timing in clocks
   localparam int CLK_PER_MC = 4;
   localparam int ONCHIP_MC = 2;
   localparam int ADDR_MC = 1;
   localparam int ALE_CLKS = 2;
   localparam logic [5:0] ONCHIP_CNT = 6'(ONCHIP_MC * CLK_PER_MC - 1);
   localparam logic [5:0] ADDR_CNT = 6'(ADDR_MC * CLK_PER_MC - 1);
   localparam logic [5:0] ALE_DROP = 6'(CLK_PER_MC - ALE_CLKS);
   localparam logic [5:0] MC_CNT = 6'(CLK_PER_MC);
   // External-data move sequencer states
   typedef enum logic [1:0] {X_IDLE, X_ONCHIP, X_ADDR, X_STROBE} xstate_t;
endpackage : dmd_pkg

// File: tb/ext_data_memory.sv
`timescale 1ns/10ps
module ext_data_memory (
   input wire logic i_clk,
   input wire logic i_ale,
   input wire logic i_rd_n,
   input wire logic i_wr_n,
   input wire logic [7:0] i_high_address_port,
   input wire logic [7:0] i_low_address_port_out,
   input wire logic [7:0] i_low_address_port_oe_n,
   output logic [7:0] o_pins
);
   logic [7:0] mem [0:65535];
   bit wr_seen [0:65535];
   logic [15:0] addr_reg = 16'h0000;
   logic [7:0] float_reg = 8'h55;
   logic [7:0] rd_byte;
   // Unwritten places return a pattern tied to the address, so stale data shows
   always @* begin
      rd_byte = wr_seen[addr_reg] ? mem[addr_reg] : (addr_reg[7:0] ^ 8'h3C);
   end
   // open drain wire
   // Undriven bits wander each cycle, so a missed drive is never read as a match
   assign o_pins = (~i_low_address_port_oe_n & i_low_address_port_out)
      | (i_low_address_port_oe_n & (!i_rd_n ? rd_byte : float_reg));
   // address latch
   // Address is taken while ale is high, data written while the strobe is low
   always @(posedge i_clk) begin
      float_reg <= ~float_reg;
      if (i_ale) addr_reg <= {i_high_address_port, o_pins};
      if (!i_wr_n) begin
         mem[addr_reg] <= o_pins;
         wr_seen[addr_reg] <= 1'b1;
      end
   end
endmodule : ext_data_memory

// File: tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
   import dmd_pkg::*;
   logic i_clk, i_reset_n, i_clk_en, i_dir_wr, i_ind_wr, i_bit_wr, i_bit_val, i_sp_push, i_sp_pop;
   logic i_dp_load, i_dp_inc, i_dp_dec, i_xm_req, i_xm_wr, o_bit_rdata;
   logic o_xm_busy, o_xm_done, o_ale, o_rd_n, o_wr_n;
   logic [7:0] i_dir_addr, i_dir_wdata, i_ind_addr, i_ind_wdata, i_bit_addr, i_xm_wdata;
   logic [7:0] o_dir_rdata, o_ind_rdata, o_stack_top, o_xm_rdata, pins;
   logic [7:0] o_low_address_port_out, o_low_address_port_oe_n, o_high_address_port;
   logic [15:0] i_dp_wdata, i_xm_addr, o_active_data_pointer;
   logic [2:0] i_stretch;
   int n_mismatch = 0;
   int num_checks = 0;
   int cyc = 0;
   // Clock enable drops only in the freeze test; bus timing needs it held high
   data_memory_decode_dual_pointer data_memory_decode_dual_pointer_i (
      .i_clk(i_clk), .i_reset_n(i_reset_n), .i_clk_en(i_clk_en), .i_dir_addr(i_dir_addr),
      .i_dir_wr(i_dir_wr), .i_dir_wdata(i_dir_wdata), .o_dir_rdata(o_dir_rdata),
      .i_ind_addr(i_ind_addr), .i_ind_wr(i_ind_wr), .i_ind_wdata(i_ind_wdata),
      .o_ind_rdata(o_ind_rdata), .i_bit_addr(i_bit_addr), .i_bit_wr(i_bit_wr),
      .i_bit_val(i_bit_val), .o_bit_rdata(o_bit_rdata), .i_sp_push(i_sp_push),
      .i_sp_pop(i_sp_pop), .o_stack_top(o_stack_top), .i_dp_load(i_dp_load),
      .i_dp_wdata(i_dp_wdata), .i_dp_inc(i_dp_inc), .i_dp_dec(i_dp_dec),
      .o_active_data_pointer(o_active_data_pointer), .i_xm_req(i_xm_req),
      .i_xm_wr(i_xm_wr), .i_xm_addr(i_xm_addr), .i_xm_wdata(i_xm_wdata),
      .i_stretch(i_stretch), .o_xm_busy(o_xm_busy), .o_xm_done(o_xm_done),
      .o_xm_rdata(o_xm_rdata), .i_low_address_port_in(pins),
      .o_low_address_port_out(o_low_address_port_out),
      .o_low_address_port_oe_n(o_low_address_port_oe_n),
      .o_high_address_port(o_high_address_port), .o_ale(o_ale), .o_rd_n(o_rd_n),
      .o_wr_n(o_wr_n));
   ext_data_memory ext_data_memory_i (
      .i_clk(i_clk), .i_ale(o_ale), .i_rd_n(o_rd_n), .i_wr_n(o_wr_n),
      .i_high_address_port(o_high_address_port),
      .i_low_address_port_out(o_low_address_port_out),
      .i_low_address_port_oe_n(o_low_address_port_oe_n), .o_pins(pins));
   // Free-running clock, 20 ns period
   initial begin
      i_clk = 1'b0;
      forever #10 i_clk = ~i_clk;
   end
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : give_verdict
   // Hang guard, far above the 150 or so cycles the tests need
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         give_verdict();
      end
   end
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // Strobes rise and fall on falling edges, so one rising edge takes each
   task automatic pulse(ref logic s);
      @(negedge i_clk);
      s = 1'b1;
      @(negedge i_clk);
      s = 1'b0;
   endtask : pulse
   task automatic wr_dir(input logic [7:0] a, input logic [7:0] d);
      @(negedge i_clk);
      i_dir_addr = a;
      i_dir_wdata = d;
      i_dir_wr = 1'b1;
      @(negedge i_clk);
      i_dir_wr = 1'b0;
   endtask : wr_dir
   task automatic rd_dir(input logic [7:0] a, input logic [7:0] e);
      @(negedge i_clk);
      i_dir_addr = a;
      @(posedge i_clk);
      #1;
      chk("dir_rdata", 16'(e), 16'(o_dir_rdata));
   endtask : rd_dir
   task automatic rd_ind(input logic [7:0] a, input logic [7:0] e);
      @(negedge i_clk);
      i_ind_addr = a;
      @(posedge i_clk);
      #1;
      chk("ind_rdata", 16'(e), 16'(o_ind_rdata));
   endtask : rd_ind
   task automatic wr_bit(input logic [7:0] a, input logic v);
      @(negedge i_clk);
      i_bit_addr = a;
      i_bit_val = v;
      i_bit_wr = 1'b1;
      @(negedge i_clk);
      i_bit_wr = 1'b0;
   endtask : wr_bit
   // Registered outputs get one spare edge before they are compared
   task automatic chk_dp(input logic [15:0] e);
      @(posedge i_clk);
      #1;
      chk("active_pointer", e, o_active_data_pointer);
   endtask : chk_dp
   // One move; ext says whether the bus must be used at all
   task automatic xmove(input logic w, input logic [15:0] a, input logic [7:0] d,
         input logic [2:0] s, input int ecyc, input logic [7:0] e, input logic ext);
      int n;
      logic used;
      logic [7:0] hp;
      n = -1;
      used = 1'b0;
      hp = 8'h00;
      @(negedge i_clk);
      i_xm_req = 1'b1;
      i_xm_wr = w;
      i_xm_addr = a;
      i_xm_wdata = d;
      i_stretch = s;
      while (n < 100) begin
         @(posedge i_clk);
         #1;
         n++;
         if (o_ale === 1'b1) hp = o_high_address_port;
         if (o_ale === 1'b1 || o_rd_n === 1'b0 || o_wr_n === 1'b0) used = 1'b1;
         if (o_xm_done === 1'b1) break;
         if (n == 0) begin
            chk("xm_busy", 16'h0001, 16'(o_xm_busy));
            @(negedge i_clk);
            i_xm_req = 1'b0;
         end
      end
      chk("xm_cycles", 16'(ecyc), 16'(n));
      chk("xm_busy_end", 16'h0000, 16'(o_xm_busy));
      chk("xm_bus_used", 16'(ext), 16'(used));
      if (ext) chk("high_port", 16'(a[15:8]), 16'(hp));
      if (!w) chk("xm_rdata", 16'(e), 16'(o_xm_rdata));
      chk("high_port_idle", 16'h00FF, 16'(o_high_address_port));
   endtask : xmove
   // Main sequence
   initial begin
      i_clk_en = 1'b1;
      {i_dir_wr, i_ind_wr, i_bit_wr, i_bit_val, i_sp_push, i_sp_pop} = 6'h00;
      {i_dp_load, i_dp_inc, i_dp_dec, i_xm_req, i_xm_wr} = 5'h00;
      {i_dir_addr, i_dir_wdata, i_ind_addr, i_ind_wdata, i_bit_addr} = 40'h0;
      {i_dp_wdata, i_xm_addr, i_xm_wdata, i_stretch} = 43'h0;
      i_reset_n = 1'b0;
      repeat (6) @(posedge i_clk);
      @(negedge i_clk);
      i_reset_n = 1'b1;
      chk("stack_top", 16'(RST_STACK), 16'(o_stack_top));
      chk_dp(16'h0000);
      chk("port_oe_n", 16'h00FF, 16'(o_low_address_port_oe_n));
      rd_dir(8'h81, 8'h07);
      for (int i = 8'h82; i <= 8'h85; i++) rd_dir(8'(i), 8'h00);
      rd_dir(8'h86, 8'h00);
      rd_dir(8'hC4, 8'hFE);
      rd_dir(8'h8F, 8'hFF);
      rd_dir(8'h87, 8'hFF);
      $display("test reset values done");
      wr_dir(8'h82, 8'h34);
      wr_dir(8'h83, 8'h12);
      wr_dir(8'h84, 8'h78);
      wr_dir(8'h85, 8'h56);
      rd_dir(8'h84, 8'h78);
      chk_dp(16'h1234);
      wr_dir(8'h86, 8'hFF);
      rd_dir(8'h86, 8'h01);
      chk_dp(16'h5678);
      pulse(i_dp_inc);
      chk_dp(16'h5679);
      rd_dir(8'h84, 8'h79);
      rd_dir(8'h82, 8'h34);
      pulse(i_dp_dec);
      chk_dp(16'h5678);
      @(negedge i_clk);
      i_dp_wdata = 16'hABCD;
      pulse(i_dp_load);
      rd_dir(8'h85, 8'hAB);
      wr_dir(8'h86, 8'h00);
      chk_dp(16'h1234);
      $display("test pointers done");
      pulse(i_sp_push);
      pulse(i_sp_push);
      pulse(i_sp_pop);
      rd_dir(8'h81, 8'h08);
      chk("stack_top", 16'h0008, 16'(o_stack_top));
      // Clock enable low must freeze the stack through a push strobe
      @(negedge i_clk);
      i_clk_en = 1'b0;
      pulse(i_sp_push);
      i_clk_en = 1'b1;
      chk("stack_frozen", 16'h0008, 16'(o_stack_top));
      $display("test stack done");
      wr_dir(8'h30, 8'hC3);
      rd_ind(8'h30, 8'hC3);
      @(negedge i_clk);
      i_ind_addr = 8'hA0;
      i_ind_wdata = 8'h5A;
      pulse(i_ind_wr);
      rd_ind(8'hA0, 8'h5A);
      rd_dir(8'hA0, 8'hFF);
      wr_dir(8'h21, 8'h00);
      wr_bit(8'h0B, 1'b1);
      rd_dir(8'h21, 8'h08);
      chk("bit_rdata", 16'h0001, 16'(o_bit_rdata));
      wr_bit(8'h81, 1'b0);
      @(negedge i_clk);
      chk("port_oe_n", 16'h00FD, 16'(o_low_address_port_oe_n));
      wr_bit(8'h81, 1'b1);
      $display("test scratchpad and bits done");
      xmove(1'b1, 16'h1234, 8'h5A, 3'd0, 8, 8'h00, 1'b1);
      xmove(1'b0, 16'h1234, 8'h00, 3'd0, 8, 8'h5A, 1'b1);
      xmove(1'b0, 16'hFFFF, 8'h00, 3'd2, 16, 8'hC3, 1'b1);
      wr_dir(8'hC4, 8'h01);
      rd_dir(8'hC4, 8'hFF);
      xmove(1'b1, 16'h03FF, 8'hA5, 3'd7, 8, 8'h00, 1'b0);
      xmove(1'b0, 16'h03FF, 8'h00, 3'd7, 8, 8'hA5, 1'b0);
      xmove(1'b0, 16'h0400, 8'h00, 3'd0, 8, 8'h3C, 1'b1);
      wr_dir(8'hC4, 8'h00);
      xmove(1'b0, 16'h03FF, 8'h00, 3'd1, 12, 8'hC3, 1'b1);
      $display("test external moves done");
      give_verdict();
   end
endmodule : tb_top
